// file: pkg/bsl_pkg.sv
package bsl_pkg;

  // strap pin order: index 0 is the async memory address bit 8
  localparam int unsigned PIN_W       = 6;
  localparam int unsigned CFG_W       = 4;
  localparam int unsigned BOOT_W      = 2;
  localparam int unsigned PF_W        = 5;
  localparam int unsigned CFG_LSB     = 0;
  localparam int unsigned BOOT_LSB    = 4;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_PINFUNC  = 8'h04;
  localparam logic [7:0] OFS_PINMODE  = 8'h08;
  localparam logic [7:0] OFS_GPIO     = 8'h0C;
  localparam logic [7:0] OFS_PININ    = 8'h10;

  // status field positions
  localparam int unsigned ST_BOOT_LSB  = 0;
  localparam int unsigned ST_CFG_LSB   = 2;
  localparam int unsigned ST_VALID_BIT = 8;

  // pin_function_select_two field positions
  localparam int unsigned PF_UDB_BIT   = 0;
  localparam int unsigned PF_BA0_LSB   = 1;
  localparam int unsigned PF_LAB1_BIT  = 3;
  localparam int unsigned PF_A133_BIT  = 4;

  // gpio register field positions
  localparam int unsigned GPIO_OUT_LSB = 0;
  localparam int unsigned GPIO_OE_LSB  = 8;

  // values after reset, before the straps are loaded
  localparam logic [4:0] PF_RST       = 5'h00;
  localparam logic [5:0] PINMODE_RST  = 6'h00;
  localparam logic [5:0] GPIO_RST     = 6'h00;

  // bank_addr0_function codes
  localparam logic [1:0] BA0_BANK     = 2'h0;
  localparam logic [1:0] BA0_ADDR14   = 2'h1;
  localparam logic [1:0] BA0_GPIO54   = 2'h2;
  localparam logic [1:0] BA0_RSVD     = 2'h3;

  typedef enum logic [2:0] {
    BSL_ST_RESET  = 3'h1,
    BSL_ST_SAMPLE = 3'h2,
    BSL_ST_RUN    = 3'h4
  } bsl_state_t;

endpackage

// file: pkg/bsl_strap_if.sv
interface bsl_strap_if;
  logic [1:0] boot_code;
  logic [3:0] cfg_code;
  logic       valid;
  logic       load;

  modport cap (output boot_code, output cfg_code, output valid, output load);
  modport use_side (input boot_code, input cfg_code, input valid, input load);
endinterface

// file: design/bsl_capture.sv
module bsl_capture (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] pin_i,
  bsl_strap_if.cap        strap
);

  bsl_pkg::bsl_state_t state;
  bsl_pkg::bsl_state_t next_state;
  logic [1:0]          boot_code;
  logic [1:0]          next_boot_code;
  logic [3:0]          cfg_code;
  logic [3:0]          next_cfg_code;
  logic                load;
  logic                next_load;

  ////////////////////////////////////////////////////////////////////////////
  // one idle cycle after release lets the pulls settle before sampling
  always_comb begin
    next_state     = state;
    next_boot_code = boot_code;
    next_cfg_code  = cfg_code;
    next_load      = 1'b0;
    case (state)
      bsl_pkg::BSL_ST_RESET: begin
        next_state = bsl_pkg::BSL_ST_SAMPLE;
      end
      bsl_pkg::BSL_ST_SAMPLE: begin
        next_boot_code = pin_i[bsl_pkg::BOOT_LSB +: 2];
        next_cfg_code  = pin_i[bsl_pkg::CFG_LSB +: 4];
        next_load      = 1'b1;
        next_state     = bsl_pkg::BSL_ST_RUN;
      end
      bsl_pkg::BSL_ST_RUN: begin
        next_state = bsl_pkg::BSL_ST_RUN;
      end
      default: begin
        next_state = bsl_pkg::BSL_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= bsl_pkg::BSL_ST_RESET;
      boot_code <= 2'h0;
      cfg_code  <= 4'h0;
      load      <= 1'b0;
    end else begin
      state     <= next_state;
      boot_code <= next_boot_code;
      cfg_code  <= next_cfg_code;
      load      <= next_load;
    end
  end

  assign strap.boot_code = boot_code;
  assign strap.cfg_code  = cfg_code;
  assign strap.valid     = (state == bsl_pkg::BSL_ST_RUN);
  assign strap.load      = load;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sample;
    state == bsl_pkg::BSL_ST_SAMPLE;
  endsequence

  boot_capture_a: assert property (
    s_sample |=> boot_code == $past(pin_i[5:4]) && strap.valid && load)
    else $error("boot select not captured from straps");

  cfg_capture_a: assert property (
    s_sample |=> cfg_code == $past(pin_i[3:0]))
    else $error("config strap not captured");

  code_hold_a: assert property (
    strap.valid && $past(strap.valid) |-> $stable(boot_code)
      && $stable(cfg_code))
    else $error("captured straps changed after capture");

endmodule

// file: design/bsl_top.sv
// Function
// - latch two boot-select straps, choose boot method
// - latch four memory-config straps at reset
// - config bit 3 sets data-width field default
// - config bits 2:1 set bank-address-0 field default
// - config bit 0 sets both address-width field defaults
// - strap pins become address/gpio after capture
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
module bsl_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [5:0]  strap_pin_i,
  output logic      [5:0]  strap_pin_o,
  output logic      [5:0]  strap_pin_oe_o,
  input  wire logic [5:0]  mem_addr_i,
  input  wire logic        mem_addr_oe_i,
  output logic      [1:0]  boot_select_o,
  output logic             boot_valid_o,
  output logic      [3:0]  async_mem_config_strap_o,
  output logic             upper_data_byte_function_o,
  output logic      [1:0]  bank_addr0_function_o,
  output logic             ba0_is_bank_addr_o,
  output logic             ba0_is_addr14_o,
  output logic             ba0_is_gpio54_o,
  output logic             low_addr_bank1_function_o,
  output logic             addr_13_to_3_function_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  bsl_strap_if strap ();

  bsl_capture u_capture (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (strap_pin_i),
    .strap (strap)
  );

  logic [4:0]  pinfunc;
  logic [4:0]  next_pinfunc;
  logic [5:0]  pin_mode;
  logic [5:0]  next_pin_mode;
  logic [5:0]  gpio_out;
  logic [5:0]  next_gpio_out;
  logic [5:0]  gpio_oe;
  logic [5:0]  next_gpio_oe;
  logic        ack;
  logic        next_ack;
  logic [31:0] dat;
  logic [31:0] next_dat;
  logic        req;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [4:0]  strap_pf;

  // requests wait until the straps are in and the defaults are loaded
  assign req = wb_cyc_i && wb_stb_i && strap.valid && !strap.load && !ack;

  // field defaults taken from the captured config code
  assign strap_pf = {strap.cfg_code[0],
                     strap.cfg_code[0],
                     strap.cfg_code[2:1],
                     strap.cfg_code[3]};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_word = 32'h0;
    case (wb_adr_i)
      bsl_pkg::OFS_STATUS: begin
        rd_word[bsl_pkg::ST_BOOT_LSB +: 2] = strap.boot_code;
        rd_word[bsl_pkg::ST_CFG_LSB +: 4]  = strap.cfg_code;
        rd_word[bsl_pkg::ST_VALID_BIT]     = strap.valid;
      end
      bsl_pkg::OFS_PINFUNC: begin
        rd_word[4:0] = pinfunc;
      end
      bsl_pkg::OFS_PINMODE: begin
        rd_word[5:0] = pin_mode;
      end
      bsl_pkg::OFS_GPIO: begin
        rd_word[bsl_pkg::GPIO_OUT_LSB +: 6] = gpio_out;
        rd_word[bsl_pkg::GPIO_OE_LSB +: 6]  = gpio_oe;
      end
      bsl_pkg::OFS_PININ: begin
        rd_word[5:0] = strap_pin_i;
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  always_comb begin
    next_pinfunc  = pinfunc;
    next_pin_mode = pin_mode;
    next_gpio_out = gpio_out;
    next_gpio_oe  = gpio_oe;
    next_ack      = 1'b0;
    next_dat      = 32'h0;
    wr_word       = merge_bytes(rd_word, wb_dat_i, wb_sel_i);
    if (strap.load) begin
      next_pinfunc = strap_pf;
    end
    if (req) begin
      next_ack = 1'b1;
      next_dat = rd_word;
      if (wb_we_i) begin
        case (wb_adr_i)
          bsl_pkg::OFS_PINFUNC: begin
            next_pinfunc = wr_word[4:0];
          end
          bsl_pkg::OFS_PINMODE: begin
            next_pin_mode = wr_word[5:0];
          end
          bsl_pkg::OFS_GPIO: begin
            next_gpio_out = wr_word[bsl_pkg::GPIO_OUT_LSB +: 6];
            next_gpio_oe  = wr_word[bsl_pkg::GPIO_OE_LSB +: 6];
          end
          default: begin
            next_pinfunc = pinfunc;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pinfunc  <= bsl_pkg::PF_RST;
      pin_mode <= bsl_pkg::PINMODE_RST;
      gpio_out <= bsl_pkg::GPIO_RST;
      gpio_oe  <= bsl_pkg::GPIO_RST;
      ack      <= 1'b0;
      dat      <= 32'h0;
    end else begin
      pinfunc  <= next_pinfunc;
      pin_mode <= next_pin_mode;
      gpio_out <= next_gpio_out;
      gpio_oe  <= next_gpio_oe;
      ack      <= next_ack;
      dat      <= next_dat;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat;

  ////////////////////////////////////////////////////////////////////////////
  // pins float to their pulls until captured; mode bit 1 selects gpio
  assign strap_pin_oe_o = strap.valid
                        ? ((pin_mode & gpio_oe)
                           | (~pin_mode & {6{mem_addr_oe_i}}))
                        : 6'h00;
  assign strap_pin_o    = (pin_mode & gpio_out) | (~pin_mode & mem_addr_i);

  assign boot_select_o              = strap.boot_code;
  assign boot_valid_o               = strap.valid;
  assign async_mem_config_strap_o   = strap.cfg_code;
  assign upper_data_byte_function_o = pinfunc[bsl_pkg::PF_UDB_BIT];
  assign bank_addr0_function_o      = pinfunc[bsl_pkg::PF_BA0_LSB +: 2];
  assign low_addr_bank1_function_o  = pinfunc[bsl_pkg::PF_LAB1_BIT];
  assign addr_13_to_3_function_o    = pinfunc[bsl_pkg::PF_A133_BIT];

  // reserved code enables none of the three uses
  assign ba0_is_bank_addr_o = (bank_addr0_function_o == bsl_pkg::BA0_BANK);
  assign ba0_is_addr14_o    = (bank_addr0_function_o == bsl_pkg::BA0_ADDR14);
  assign ba0_is_gpio54_o    = (bank_addr0_function_o == bsl_pkg::BA0_GPIO54);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    strap.load;
  endsequence

  sequence s_request;
    wb_cyc_i && wb_stb_i && strap.valid && !strap.load && !ack;
  endsequence

  udb_default_a: assert property (
    s_load |=> upper_data_byte_function_o == $past(strap.cfg_code[3]))
    else $error("data width default not loaded from strap bit 3");

  ba0_default_a: assert property (
    s_load |=> bank_addr0_function_o == $past(strap.cfg_code[2:1]))
    else $error("bank address 0 default not loaded from straps");

  ba0_decode_a: assert property (
    (bank_addr0_function_o == bsl_pkg::BA0_RSVD)
      == !(ba0_is_bank_addr_o || ba0_is_addr14_o || ba0_is_gpio54_o)
    && $onehot0({ba0_is_bank_addr_o, ba0_is_addr14_o, ba0_is_gpio54_o}))
    else $error("bank address 0 use decoded wrongly");

  addr_default_a: assert property (
    s_load |=> low_addr_bank1_function_o == $past(strap.cfg_code[0])
      && addr_13_to_3_function_o == $past(strap.cfg_code[0]))
    else $error("address width defaults not loaded from strap bit 0");

  pin_release_a: assert property (
    !boot_valid_o |-> strap_pin_oe_o == 6'h00)
    else $error("strap pin driven before capture");

  boot_out_a: assert property (
    boot_valid_o && $past(boot_valid_o) |-> $stable(boot_select_o))
    else $error("boot select changed after capture");

  ack_pulse_a: assert property (
    s_request |=> wb_ack_o ##1 !wb_ack_o)
    else $error("request not answered with one-cycle ack");

  addr_pass_a: assert property (
    boot_valid_o && pin_mode == 6'h00 |-> strap_pin_o == mem_addr_i
      && strap_pin_oe_o == {6{mem_addr_oe_i}})
    else $error("pins not carrying memory address after capture");

endmodule

// file: bench/bsl_board_model.sv
module bsl_board_model (
  input  wire logic [5:0] strap_val_i,
  input  wire logic       strap_fit_i,
  input  wire logic [5:0] dev_val_i,
  input  wire logic [5:0] dev_oe_i,
  output logic      [5:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins 2 and 3 pulled up, the rest pulled down
  localparam logic [5:0] PULL = 6'h0C;
  // strap resistors are weaker than any driver, pulls weaker still
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (dev_oe_i[i]) begin
        pin_o[i] = dev_val_i[i];
      end else if (strap_fit_i) begin
        pin_o[i] = strap_val_i[i];
      end else begin
        pin_o[i] = PULL[i];
      end
    end
  end
endmodule

// file: bench/boot_strap_latch_test.sv
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); \
  fail_count++; end end
module boot_strap_latch_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, mem_oe = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat;
  logic [5:0]  mem_addr = 6'h00, strap_val = 6'h00;
  logic        strap_fit = 1'h1, ack, valid, udb, lab1, a133;
  logic        is_bank, is_a14, is_g54;
  logic [5:0]  pin_lvl, pin_o, pin_oe;
  logic [1:0]  boot, ba0;
  logic [3:0]  cfg;
  int          fail_count = 0, checked = 0;
  logic [5:0]  tbl [5] = '{6'h05, 6'h1A, 6'h39, 6'h26, 6'h00};
  //////////////////////////////////////////////////////////////////////
  bsl_board_model bsl_board_model_inst (.strap_val_i(strap_val),
    .strap_fit_i(strap_fit), .dev_val_i(pin_o), .dev_oe_i(pin_oe),
    .pin_o(pin_lvl));
  bsl_top bsl_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .strap_pin_i(pin_lvl), .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe),
    .mem_addr_i(mem_addr), .mem_addr_oe_i(mem_oe), .boot_select_o(boot),
    .boot_valid_o(valid), .async_mem_config_strap_o(cfg),
    .upper_data_byte_function_o(udb), .bank_addr0_function_o(ba0),
    .ba0_is_bank_addr_o(is_bank), .ba0_is_addr14_o(is_a14),
    .ba0_is_gpio54_o(is_g54), .low_addr_bank1_function_o(lab1),
    .addr_13_to_3_function_o(a133));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 50);
    rd = wb_dat;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
    if (ack !== 1'h1) begin fail_count++; complete_run(); end
  endtask
  // hold straps through reset; strap_fit low leaves only the pulls
  task automatic do_reset(input logic [5:0] s, input logic fit);
    int n;
    n = 0;
    @(posedge clk_i);
    strap_val <= s; strap_fit <= fit; rst_i <= 1'h1;
    repeat (16) @(posedge clk_i);
    `CHK("oe in reset", 6'h00, pin_oe)
    `CHK("valid in reset", 1'h0, valid)
    rst_i <= 1'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (valid !== 1'h1 && n < 20);
    if (valid !== 1'h1) begin fail_count++; complete_run(); end
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic test_capture(input logic [5:0] s, input logic fit);
    logic [5:0]  e;
    logic [31:0] rd;
    e = fit ? s : 6'h0C;
    do_reset(s, fit);
    `CHK("boot", e[5:4], boot)
    `CHK("cfg", e[3:0], cfg)
    `CHK("udb", e[3], udb)
    `CHK("ba0", e[2:1], ba0)
    `CHK("ba0 dec", {e[2:1] == 2'h2, e[2:1] == 2'h1, e[2:1] == 2'h0},
         {is_g54, is_a14, is_bank})
    `CHK("addr width", {e[0], e[0]}, {lab1, a133})
    wb(1'h0, bsl_pkg::OFS_STATUS, 32'h0, rd);
    `CHK("status", {23'h0, 1'h1, 2'h0, e[3:0], e[5:4]}, rd)
    wb(1'h0, bsl_pkg::OFS_PINFUNC, 32'h0, rd);
    `CHK("pinfunc", {27'h0, e[0], e[0], e[2:1], e[3]}, rd)
    // later pin levels must not reach the captured codes
    strap_val <= ~e; strap_fit <= 1'h1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("late pins", {e[5:4], e[3:0]}, {boot, cfg})
    $display("capture test %h done", e);
  endtask
  task automatic test_pins();
    logic [31:0] rd;
    do_reset(6'h05, 1'h1);
    @(posedge clk_i);
    mem_oe <= 1'h1; mem_addr <= 6'h2A;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("addr pins", {6'h3F, 6'h2A}, {pin_oe, pin_o})
    wb(1'h0, bsl_pkg::OFS_PININ, 32'h0, rd);
    `CHK("pinin addr", 32'h2A, rd)
    wb(1'h1, bsl_pkg::OFS_STATUS, 32'hFFFFFFFF, rd);
    wb(1'h0, bsl_pkg::OFS_STATUS, 32'h0, rd);
    `CHK("status ro", 32'h114, rd)
    wb(1'h1, bsl_pkg::OFS_PINFUNC, 32'h16, rd);
    wb(1'h0, bsl_pkg::OFS_PINFUNC, 32'h0, rd);
    `CHK("pinfunc rw", 32'h16, rd)
    wb(1'h1, bsl_pkg::OFS_PINMODE, 32'h3F, rd);
    wb(1'h1, bsl_pkg::OFS_GPIO, 32'h1533, rd);
    @(negedge clk_i);
    `CHK("gpio pins", {6'h15, 6'h11}, {pin_oe, pin_o & pin_oe})
    wb(1'h0, bsl_pkg::OFS_PININ, 32'h0, rd);
    `CHK("pinin gpio", 32'h11, rd)
    wb(1'h0, 8'h20, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("pin test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 5; i++) begin
      test_capture(tbl[i], i < 4);
    end
    test_pins();
    complete_run();
  end
endmodule
